// File: common/smre_pkg.sv
// constants shared by the management-interrupt routing block
// assumes a 32-bit apb slave with 12-bit byte addresses
package smre_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [9:0]  SMRE_IDX_EN_A     = 10'h0B4;  // first enable register
    localparam logic [9:0]  SMRE_IDX_EN_B     = 10'h0B5;  // second enable register
    localparam logic [9:0]  SMRE_IDX_ST_A     = 10'h0B6;  // first source status
    localparam logic [9:0]  SMRE_IDX_ST_B     = 10'h0B7;  // second source status
    localparam logic [11:0] SMRE_ADDR_EN_A    = {SMRE_IDX_EN_A, 2'b00};
    localparam logic [11:0] SMRE_ADDR_EN_B    = {SMRE_IDX_EN_B, 2'b00};
    localparam logic [11:0] SMRE_ADDR_ST_A    = {SMRE_IDX_ST_A, 2'b00};
    localparam logic [11:0] SMRE_ADDR_ST_B    = {SMRE_IDX_ST_B, 2'b00};
    // event interrupt registers
    localparam logic [11:0] SMRE_ADDR_IRQ_ST  = 12'h300;  // sticky events, write one to clear
    localparam logic [11:0] SMRE_ADDR_IRQ_MSK = 12'h304;  // event mask, one passes

    // reset values
    localparam logic [7:0]  SMRE_RST_EN       = 8'h00;
    localparam logic [7:0]  SMRE_RST_ST       = 8'h00;
    localparam logic [1:0]  SMRE_RST_IRQ      = 2'h0;

    // implemented bits of each register
    localparam logic [7:0]  SMRE_MASK_A       = 8'h9E;    // bits 1,2,3,4,7
    localparam logic [7:0]  SMRE_MASK_B_SRC   = 8'h17;    // bits 0,1,2,4
    localparam logic [7:0]  SMRE_MASK_B       = 8'hD7;    // sources plus bits 6,7

    // field positions, first enable / status register
    localparam int SMRE_BIT_PAR   = 1;
    localparam int SMRE_BIT_UART2 = 2;
    localparam int SMRE_BIT_UART1 = 3;
    localparam int SMRE_BIT_FLOP  = 4;
    localparam int SMRE_BIT_WDT   = 7;
    // field positions, second enable / status register
    localparam int SMRE_BIT_MOUSE = 0;
    localparam int SMRE_BIT_KBD   = 1;
    localparam int SMRE_BIT_IR    = 2;
    localparam int SMRE_BIT_P12   = 4;
    localparam int SMRE_BIT_SER   = 6;
    localparam int SMRE_BIT_PIN   = 7;
    // event interrupt bits
    localparam int SMRE_EV_GROUP  = 0;
    localparam int SMRE_EV_IR     = 1;

endpackage

// File: common/smre_src_if.sv
// carries source status and its read-clear between status and top modules
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface smre_src_if;
    logic [7:0] status_a;     // first source status
    logic [7:0] status_b;     // second source status
    logic       clear_ir;     // read of second status register completes

    // status keeper drives status, reads the clear
    modport keeper (output status_a, output status_b, input clear_ir);
    // register side reads status, drives the clear
    modport user   (input status_a, input status_b, output clear_ir);
endinterface
`default_nettype wire

// File: logic/smre_status.sv
// source status capture for the management-interrupt routing block
// assumes all source inputs are synchronous to pclk and active high
`timescale 1ns/1ps
`default_nettype none
module smre_status (
    input  wire logic pclk,                  // bus clock
    input  wire logic presetn,               // async reset, low active
    input  wire logic parallel_irq_line,     // parallel port interrupt
    input  wire logic second_uart_irq,       // second uart interrupt
    input  wire logic first_uart_irq,        // first uart interrupt
    input  wire logic floppy_irq,            // floppy interrupt
    input  wire logic watchdog_irq,          // watchdog interrupt
    input  wire logic mouse_irq,             // mouse interrupt
    input  wire logic keyboard_irq,          // keyboard interrupt
    input  wire logic ir_rx_muxed,           // ir receive after location mux
    input  wire logic kbc_port1_bit2,        // keyboard controller port bit
    output logic      ir_edge_event,         // one-cycle pulse on ir transition
    smre_src_if.keeper src                   // status toward the top
);
    import smre_pkg::*;

    logic [7:0] st_a;           // first status
    logic [7:0] st_b;           // second status
    logic       ir_prev;        // last ir level
    logic       ir_primed;      // ir_prev holds a real sample
    logic [7:0] next_st_a;
    logic [7:0] next_st_b;
    logic       next_ir_prev;
    logic       next_ir_primed;
    logic       ir_toggle;

    // next status: levels follow sources, ir bit is sticky
    always_comb begin
        ir_toggle      = ir_primed && (ir_rx_muxed != ir_prev);
        next_ir_prev   = ir_rx_muxed;
        next_ir_primed = 1'b1;
        next_st_a      = SMRE_RST_ST;
        next_st_b      = SMRE_RST_ST;
        // source bits clear only when the unit drops its request
        next_st_a[SMRE_BIT_PAR]   = parallel_irq_line;  // [R6]
        next_st_a[SMRE_BIT_UART2] = second_uart_irq;    // [R6]
        next_st_a[SMRE_BIT_UART1] = first_uart_irq;     // [R6]
        next_st_a[SMRE_BIT_FLOP]  = floppy_irq;         // [R6]
        next_st_a[SMRE_BIT_WDT]   = watchdog_irq;       // [R6]
        next_st_b[SMRE_BIT_MOUSE] = mouse_irq;          // [R6]
        next_st_b[SMRE_BIT_KBD]   = keyboard_irq;       // [R6]
        next_st_b[SMRE_BIT_P12]   = kbc_port1_bit2;     // [R6]
        // a transition in the clearing cycle keeps the bit set
        if (ir_toggle) begin
            next_st_b[SMRE_BIT_IR] = 1'b1; // [R7]
        end else if (src.clear_ir) begin
            next_st_b[SMRE_BIT_IR] = 1'b0; // [R7]
        end else begin
            next_st_b[SMRE_BIT_IR] = st_b[SMRE_BIT_IR];
        end
    end

    // status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_a      <= SMRE_RST_ST;
            st_b      <= SMRE_RST_ST;
            ir_prev   <= 1'b0;
            ir_primed <= 1'b0;
        end else begin
            st_a      <= next_st_a;
            st_b      <= next_st_b;
            ir_prev   <= next_ir_prev;
            ir_primed <= next_ir_primed;
        end
    end

    assign src.status_a  = st_a;
    assign src.status_b  = st_b;
    assign ir_edge_event = ir_toggle;
endmodule
`default_nettype wire

// File: logic/smre_top.sv
// management-interrupt routing block: enables, status, group output, apb slave
// assumes an apb master on pclk and source lines synchronous to pclk
//
// How it works
// [R1] first enable register gates five sources
// [R2] second enable gates mouse, keyboard, ir
// [R3] bit four routes keyboard port bit
// [R4] bit six forwards group to serial irq
// [R5] bit seven drives pin, else pin floats
// [R6] source status clears only at its source
// [R7] ir bit sets on transition, read clears
// [R8] group low on enabled status; reserved zero
`timescale 1ns/1ps
`default_nettype none
module smre_top (
    input  wire logic        pclk,               // bus clock, 100 MHz
    input  wire logic        presetn,            // async reset, low active
    input  wire logic [11:0] paddr,              // apb byte address
    input  wire logic        psel,               // apb select
    input  wire logic        penable,            // apb access phase
    input  wire logic        pwrite,             // apb direction, high writes
    input  wire logic [31:0] pwdata,             // apb write data
    input  wire logic [3:0]  pstrb,              // apb byte strobes
    output logic      [31:0] prdata,             // apb read data
    output logic             pready,             // apb ready
    output logic             pslverr,            // apb error on unmapped address
    input  wire logic        parallel_irq_line,  // parallel port interrupt
    input  wire logic        second_uart_irq,    // second uart interrupt
    input  wire logic        first_uart_irq,     // first uart interrupt
    input  wire logic        floppy_irq,         // floppy interrupt
    input  wire logic        watchdog_irq,       // watchdog interrupt
    input  wire logic        mouse_irq,          // mouse interrupt
    input  wire logic        keyboard_irq,       // keyboard interrupt
    input  wire logic        ir_rx_muxed,        // ir receive after location mux
    input  wire logic        kbc_port1_bit2,     // keyboard controller port bit
    output logic             group_mgmt_int_n,   // group interrupt, low active
    output logic             mgmt_pin_o,         // management pin drive level
    output logic             mgmt_pin_oe,        // management pin output enable
    output logic             serial_irq_mgmt,    // group request onto serial irq
    output logic             irq                 // event interrupt, high active
);
    import smre_pkg::*;

    smre_src_if src ();                          // status link to keeper

    // enable registers
    logic [7:0]  mgmt_int_enable_a;              // first enable register
    logic [7:0]  mgmt_int_enable_b;              // second enable register
    logic [7:0]  next_mgmt_int_enable_a;
    logic [7:0]  next_mgmt_int_enable_b;
    // event interrupt registers
    logic [1:0]  irq_status;                     // sticky events
    logic [1:0]  irq_mask;                       // event mask
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_mask;
    // bus state
    logic [31:0] next_prdata;
    logic        setup_phase;                    // first cycle of a transfer
    logic        access_done;                    // completing edge of a transfer
    logic        wr_done;                        // completing write
    logic        rd_done;                        // completing read
    logic        addr_hit;                       // address is mapped
    logic        lane0_wr;                       // low byte lane written
    // group logic
    logic        group_active;                   // group request, high active
    logic        group_prev;                     // group state one cycle ago
    logic        next_group_n;
    logic        next_group_prev;
    logic        next_pin_o;
    logic        next_pin_oe;
    logic        next_serial;
    logic        next_irq;
    logic        ir_edge_event;                  // ir transition pulse
    // named enable bits
    logic        gate_parallel_port_src;
    logic        gate_second_uart_src;
    logic        gate_first_uart_src;
    logic        gate_floppy_src;
    logic        gate_watchdog_src;
    logic        gate_mouse_src;
    logic        gate_keyboard_src;
    logic        gate_ir_event_src;
    logic        gate_kbc_port_bit_src;
    logic        group_to_serial_irq;
    logic        group_to_output_pin;

    // status keeper
    smre_status u_status (
        .pclk              (pclk),
        .presetn           (presetn),
        .parallel_irq_line (parallel_irq_line),
        .second_uart_irq   (second_uart_irq),
        .first_uart_irq    (first_uart_irq),
        .floppy_irq        (floppy_irq),
        .watchdog_irq      (watchdog_irq),
        .mouse_irq         (mouse_irq),
        .keyboard_irq      (keyboard_irq),
        .ir_rx_muxed       (ir_rx_muxed),
        .kbc_port1_bit2    (kbc_port1_bit2),
        .ir_edge_event     (ir_edge_event),
        .src               (src.keeper)
    );

    // bus phase decode; the slave never waits
    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable;
        wr_done     = access_done && pwrite;
        rd_done     = access_done && !pwrite;
        lane0_wr    = wr_done && pstrb[0];
        unique case (paddr)
            SMRE_ADDR_EN_A,
            SMRE_ADDR_EN_B,
            SMRE_ADDR_ST_A,
            SMRE_ADDR_ST_B,
            SMRE_ADDR_IRQ_ST,
            SMRE_ADDR_IRQ_MSK: addr_hit = 1'b1;
            default:           addr_hit = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = access_done && !addr_hit;

    // a completed read of the second status register drops the ir bit
    assign src.clear_ir = rd_done && (paddr == SMRE_ADDR_ST_B); // [R7]

    // named views of the enable fields
    always_comb begin
        gate_parallel_port_src = mgmt_int_enable_a[SMRE_BIT_PAR];
        gate_second_uart_src   = mgmt_int_enable_a[SMRE_BIT_UART2];
        gate_first_uart_src    = mgmt_int_enable_a[SMRE_BIT_UART1];
        gate_floppy_src        = mgmt_int_enable_a[SMRE_BIT_FLOP];
        gate_watchdog_src      = mgmt_int_enable_a[SMRE_BIT_WDT];
        gate_mouse_src         = mgmt_int_enable_b[SMRE_BIT_MOUSE];
        gate_keyboard_src      = mgmt_int_enable_b[SMRE_BIT_KBD];
        gate_ir_event_src      = mgmt_int_enable_b[SMRE_BIT_IR];
        gate_kbc_port_bit_src  = mgmt_int_enable_b[SMRE_BIT_P12];
        group_to_serial_irq    = mgmt_int_enable_b[SMRE_BIT_SER];
        group_to_output_pin    = mgmt_int_enable_b[SMRE_BIT_PIN];
    end

    // next enable values; reserved bits stay zero
    always_comb begin
        next_mgmt_int_enable_a = mgmt_int_enable_a;
        next_mgmt_int_enable_b = mgmt_int_enable_b;
        if (lane0_wr && paddr == SMRE_ADDR_EN_A) begin
            next_mgmt_int_enable_a = pwdata[7:0] & SMRE_MASK_A;  // [R1] [R8]
        end
        if (lane0_wr && paddr == SMRE_ADDR_EN_B) begin
            next_mgmt_int_enable_b = pwdata[7:0] & SMRE_MASK_B;  // [R2] [R8]
        end
    end

    // enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_int_enable_a <= SMRE_RST_EN; // [R1]
            mgmt_int_enable_b <= SMRE_RST_EN; // [R2]
        end else begin
            mgmt_int_enable_a <= next_mgmt_int_enable_a;
            mgmt_int_enable_b <= next_mgmt_int_enable_b;
        end
    end

    // group request from enabled status bits
    always_comb begin
        group_active = 1'b0;
        // first register sources
        if (gate_parallel_port_src && src.status_a[SMRE_BIT_PAR]) begin
            group_active = 1'b1; // [R1]
        end
        if (gate_second_uart_src && src.status_a[SMRE_BIT_UART2]) begin
            group_active = 1'b1; // [R1]
        end
        if (gate_first_uart_src && src.status_a[SMRE_BIT_UART1]) begin
            group_active = 1'b1; // [R1]
        end
        if (gate_floppy_src && src.status_a[SMRE_BIT_FLOP]) begin
            group_active = 1'b1; // [R1]
        end
        if (gate_watchdog_src && src.status_a[SMRE_BIT_WDT]) begin
            group_active = 1'b1; // [R1]
        end
        // second register sources
        if (gate_mouse_src && src.status_b[SMRE_BIT_MOUSE]) begin
            group_active = 1'b1; // [R2]
        end
        if (gate_keyboard_src && src.status_b[SMRE_BIT_KBD]) begin
            group_active = 1'b1; // [R2]
        end
        if (gate_ir_event_src && src.status_b[SMRE_BIT_IR]) begin
            group_active = 1'b1; // [R2]
        end
        // keyboard controller port bit routed internally
        if (gate_kbc_port_bit_src && src.status_b[SMRE_BIT_P12]) begin
            group_active = 1'b1; // [R3]
        end
    end

    // next values of the group outputs
    always_comb begin
        next_group_n    = !group_active; // [R8]
        next_group_prev = group_active;
        // pin floats unless routing is on; drives the low-active level
        next_pin_oe     = group_to_output_pin; // [R5]
        next_pin_o      = group_to_output_pin ? !group_active : 1'b1; // [R5]
        // serial irq stream sees the group only when forwarded
        next_serial     = group_to_serial_irq && group_active;   // [R4]
    end

    // group output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group_mgmt_int_n <= 1'b1;
            group_prev       <= 1'b0;
            mgmt_pin_o       <= 1'b1;
            mgmt_pin_oe      <= 1'b0;
            serial_irq_mgmt  <= 1'b0;
        end else begin
            group_mgmt_int_n <= next_group_n;
            group_prev       <= next_group_prev;
            mgmt_pin_o       <= next_pin_o;
            mgmt_pin_oe      <= next_pin_oe;
            serial_irq_mgmt  <= next_serial;
        end
    end

    // event status: a new event beats a write-one clear in the same cycle
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (lane0_wr && paddr == SMRE_ADDR_IRQ_ST) begin
            next_irq_status = irq_status & ~pwdata[1:0];
        end
        if (lane0_wr && paddr == SMRE_ADDR_IRQ_MSK) begin
            next_irq_mask = pwdata[1:0];
        end
        if (group_active && !group_prev) begin
            next_irq_status[SMRE_EV_GROUP] = 1'b1;
        end
        if (ir_edge_event) begin
            next_irq_status[SMRE_EV_IR] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // event interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= SMRE_RST_IRQ;
            irq_mask   <= SMRE_RST_IRQ;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= next_irq;
        end
    end

    // read data is captured in the setup cycle and held through access
    always_comb begin
        next_prdata = prdata;
        if (setup_phase) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                SMRE_ADDR_EN_A: begin
                    next_prdata[7:0] = mgmt_int_enable_a; // [R8]
                end
                SMRE_ADDR_EN_B: begin
                    next_prdata[7:0] = mgmt_int_enable_b; // [R8]
                end
                SMRE_ADDR_ST_A: begin
                    next_prdata[7:0] = src.status_a & SMRE_MASK_A;
                end
                SMRE_ADDR_ST_B: begin
                    next_prdata[7:0] = src.status_b & SMRE_MASK_B_SRC;
                end
                SMRE_ADDR_IRQ_ST: begin
                    next_prdata[1:0] = irq_status;
                end
                SMRE_ADDR_IRQ_MSK: begin
                    next_prdata[1:0] = irq_mask;
                end
                default: begin
                    next_prdata = 32'h0000_0000; // unmapped reads zero
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule
`default_nettype wire

// File: tb/smre_host_model.sv
// host receiver of the group management interrupt
// assumes a pull-up on the pin and a level serial request
`timescale 1ns/1ps
`default_nettype none
module smre_host_model (
    input  wire logic pclk,            // bus clock
    input  wire logic mgmt_pin_o,      // pin drive level
    input  wire logic mgmt_pin_oe,     // pin drive enable
    input  wire logic serial_irq_mgmt, // serial irq request
    output logic      pin_level,       // resolved pin level
    output logic      serial_seen      // request seen at last edge
);
    // released pin is pulled up, so it never reads a stale level
    assign pin_level = mgmt_pin_oe ? mgmt_pin_o : 1'b1;
    // sample the serial request once a clock, like a frame slot
    always_ff @(posedge pclk) begin
        serial_seen <= serial_irq_mgmt;
    end
endmodule
`default_nettype wire

// File: tb/smre_top_props.sv
// concurrent checks on the routing block top ports
// assumes one pclk domain and the bind below
`timescale 1ns/1ps
`default_nettype none
module smre_top_props (
    input wire logic        pclk,              // bus clock
    input wire logic        presetn,           // async reset, low
    input wire logic [11:0] paddr,             // apb address
    input wire logic        psel,              // apb select
    input wire logic        penable,           // apb access
    input wire logic        pwrite,            // apb direction
    input wire logic [31:0] prdata,            // apb read data
    input wire logic        pslverr,           // apb error
    input wire logic        parallel_irq_line, // source
    input wire logic        second_uart_irq,   // source
    input wire logic        first_uart_irq,    // source
    input wire logic        floppy_irq,        // source
    input wire logic        watchdog_irq,      // source
    input wire logic        mouse_irq,         // source
    input wire logic        keyboard_irq,      // source
    input wire logic        ir_rx_muxed,       // ir level
    input wire logic        kbc_port1_bit2,    // source
    input wire logic        group_mgmt_int_n,  // group out, low
    input wire logic        mgmt_pin_o,        // pin level
    input wire logic        mgmt_pin_oe,       // pin enable
    input wire logic        serial_irq_mgmt    // serial request
);
    import smre_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [8:0] srcs; // all event inputs
    assign srcs = {parallel_irq_line, second_uart_irq, first_uart_irq, floppy_irq,
                   watchdog_irq, mouse_irq, keyboard_irq, ir_rx_muxed, kbc_port1_bit2};
    // read at one address
    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    chk_pin_idle_high: assert property (!mgmt_pin_oe |-> mgmt_pin_o)
        else $error("pin idle low");
    chk_pin_follows_group: assert property (mgmt_pin_oe |-> mgmt_pin_o == group_mgmt_int_n)
        else $error("pin not group");
    chk_serial_needs_group: assert property (serial_irq_mgmt |-> !group_mgmt_int_n)
        else $error("serial no group");
    chk_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("stray pslverr");
    chk_enable_a_bits: assert property (s_rd(SMRE_ADDR_EN_A)
        |-> prdata[31:8] == 0 && (prdata[7:0] & ~SMRE_MASK_A) == 0)
        else $error("enable a reserved");
    chk_enable_b_bits: assert property (s_rd(SMRE_ADDR_EN_B)
        |-> prdata[31:8] == 0 && (prdata[7:0] & ~SMRE_MASK_B) == 0)
        else $error("enable b reserved");
    chk_status_a_bits: assert property (s_rd(SMRE_ADDR_ST_A) |-> (prdata & ~32'h9E) == 0)
        else $error("status a reserved");
    chk_status_b_bits: assert property (s_rd(SMRE_ADDR_ST_B) |-> (prdata & ~32'h17) == 0)
        else $error("status b reserved");
    chk_group_steady: assert property ((!psel && $stable(srcs))[*3] |=> $stable(group_mgmt_int_n))
        else $error("group moved");
endmodule
bind smre_top smre_top_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .prdata, .pslverr, .parallel_irq_line, .second_uart_irq, .first_uart_irq, .floppy_irq,
    .watchdog_irq, .mouse_irq, .keyboard_irq, .ir_rx_muxed, .kbc_port1_bit2,
    .group_mgmt_int_n, .mgmt_pin_o, .mgmt_pin_oe, .serial_irq_mgmt);
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the management-interrupt routing block
// assumes smre_top, its checker bind and the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import smre_pkg::*;
    logic        pclk = 0;             // bus clock
    logic        presetn = 0;          // reset, low
    logic [11:0] paddr = '0;           // apb address
    logic        psel = 0;             // apb select
    logic        penable = 0;          // apb access
    logic        pwrite = 0;           // apb direction
    logic [31:0] pwdata = '0;          // apb write data
    logic [31:0] prdata;               // apb read data
    logic [31:0] rd;                   // last read word
    logic        pready, pslverr, err; // apb answer
    logic        group_mgmt_int_n, mgmt_pin_o, mgmt_pin_oe, serial_irq_mgmt, irq;
    logic        pin_lvl, ser_seen;    // host view
    logic        g;                    // expected group request, high active
    logic [7:0]  sa = 0, sb = 0;       // source levels
    logic        ir = 0;               // ir receive level
    logic [7:0]  ea, eb;               // enable values written
    int          errors = 0;           // mismatches
    int          n_tests = 0;          // comparisons
    always #5 pclk = ~pclk;
    smre_top u_smre_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .parallel_irq_line(sa[1]),
        .second_uart_irq(sa[2]), .first_uart_irq(sa[3]), .floppy_irq(sa[4]),
        .watchdog_irq(sa[7]), .mouse_irq(sb[0]), .keyboard_irq(sb[1]), .ir_rx_muxed(ir),
        .kbc_port1_bit2(sb[4]), .group_mgmt_int_n, .mgmt_pin_o, .mgmt_pin_oe,
        .serial_irq_mgmt, .irq);
    smre_host_model u_smre_host_model (.pclk, .mgmt_pin_o, .mgmt_pin_oe, .serial_irq_mgmt,
        .pin_level(pin_lvl), .serial_seen(ser_seen));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        bit done;
        done = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge pclk);
            done = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
        end
        psel <= 0;
        penable <= 0;
        if (!done) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // expected group activity
    function automatic logic grp(logic [7:0] a, b, s, t);
        return |(s & a & SMRE_MASK_A) | |(t & b & SMRE_MASK_B_SRC);
    endfunction
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rd = $urandom(15124);
        repeat (20) @(posedge pclk);
        presetn <= 1;
        // reset values and reserved bits
        foreach (ea[i]) if (i < 4) begin
            apb(0, SMRE_ADDR_EN_A + 12'(4 * i), 0);
            chk("reset reg", rd, 0);
        end
        chk("reset oe", mgmt_pin_oe, 0);
        apb(0, 12'h010, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1, SMRE_ADDR_ST_A, 32'hFF);
        apb(0, SMRE_ADDR_ST_A, 0);
        chk("status write", rd, 0);
        $display("reset and map test done");
        // random routing, corners first
        for (int k = 0; k < 40; k++) begin
            ea = (k < 2) ? {8{k == 0}} : 8'($urandom);
            eb = (k < 2) ? {8{k == 0}} : 8'($urandom);
            apb(1, SMRE_ADDR_EN_A, ea);
            apb(1, SMRE_ADDR_EN_B, eb);
            apb(0, SMRE_ADDR_EN_A, 0);
            chk("enable a", rd, ea & SMRE_MASK_A);
            apb(0, SMRE_ADDR_EN_B, 0);
            chk("enable b", rd, eb & SMRE_MASK_B);
            @(posedge pclk);
            sa <= (k < 2) ? 8'hFF & SMRE_MASK_A : 8'($urandom) & SMRE_MASK_A;
            sb <= (k < 2) ? 8'h13 : 8'($urandom) & 8'h13;
            settle(3);
            g = grp(ea, eb, sa, sb);
            chk("group", group_mgmt_int_n, !g);
            chk("pin", {mgmt_pin_oe, pin_lvl}, {eb[7], !(g && eb[7])});
            chk("serial", ser_seen, g && eb[6]);
            apb(0, SMRE_ADDR_ST_A, 0);
            chk("status a", rd, sa);
            apb(0, SMRE_ADDR_ST_B, 0);
            chk("status b", rd, sb);
        end
        $display("random routing test done");
        // ir event and read clear
        apb(1, SMRE_ADDR_EN_A, 0);
        apb(1, SMRE_ADDR_EN_B, 8'h84);
        @(posedge pclk);
        sa <= 0;
        sb <= 0;
        apb(1, SMRE_ADDR_IRQ_MSK, 0);
        apb(1, SMRE_ADDR_IRQ_ST, 3);
        @(posedge pclk);
        ir <= 1;
        settle(4);
        chk("ir group", {group_mgmt_int_n, pin_lvl, irq}, 0);
        apb(1, SMRE_ADDR_IRQ_MSK, 2);
        settle(2);
        chk("irq on", irq, 1);
        apb(0, SMRE_ADDR_ST_B, 0);
        chk("ir status", rd, 32'h04);
        apb(0, SMRE_ADDR_ST_B, 0);
        chk("ir cleared", rd, 0);
        apb(1, SMRE_ADDR_IRQ_ST, 2);
        settle(3);
        chk("ir released", {group_mgmt_int_n, irq}, 2'b10);
        $display("ir event test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
